// ---- hw/gds_map.svh ----
`ifndef GDS_MAP_SVH
`define GDS_MAP_SVH

// ----------------------------------------
// clock and conversion
// ----------------------------------------
`define GDS_CLK_MHZ 125
`define GDS_NS_UP(t) ((((t) * `GDS_CLK_MHZ) + 999) / 1000)
`define GDS_NS_DN(t) (((t) * `GDS_CLK_MHZ) / 1000)

// ----------------------------------------
// drive window times, ns
// ----------------------------------------
`define GDS_T_WIN0_NS 500
`define GDS_T_WIN1_NS 1000
`define GDS_T_WIN2_NS 2000
`define GDS_T_WIN3_NS 4000
`define GDS_T_WIN_LONG_NS 20000
`define GDS_CNT_W 12
`define GDS_WIN0_CYC `GDS_NS_UP(`GDS_T_WIN0_NS)
`define GDS_WIN1_CYC `GDS_NS_UP(`GDS_T_WIN1_NS)
`define GDS_WIN2_CYC `GDS_NS_UP(`GDS_T_WIN2_NS)
`define GDS_WIN3_CYC `GDS_NS_UP(`GDS_T_WIN3_NS)
`define GDS_WIN_LONG_CYC `GDS_NS_UP(`GDS_T_WIN_LONG_NS)

// ----------------------------------------
// digital dead time, ns (code 0 adds none)
// ----------------------------------------
`define GDS_T_DEAD1_NS 100
`define GDS_T_DEAD2_NS 200
`define GDS_T_DEAD3_NS 400
`define GDS_DEAD1_CYC `GDS_NS_UP(`GDS_T_DEAD1_NS)
`define GDS_DEAD2_CYC `GDS_NS_UP(`GDS_T_DEAD2_NS)
`define GDS_DEAD3_CYC `GDS_NS_UP(`GDS_T_DEAD3_NS)

// ----------------------------------------
// filters and supervision
// ----------------------------------------
`define GDS_T_PWM_DEG_NS 40
`define GDS_PWM_DEG_CYC `GDS_NS_UP(`GDS_T_PWM_DEG_NS)
`define GDS_T_OCP_DEG_NS 4000
`define GDS_OCP_DEG_CYC `GDS_NS_UP(`GDS_T_OCP_DEG_NS)
`define GDS_T_UV_NS 100000
`define GDS_UV_CYC `GDS_NS_DN(`GDS_T_UV_NS)
`define GDS_UV_W 17
`define GDS_GATE_CURRENT_SETTING_LOW_MAX 4'h3
`define GDS_VDS_LVL_RST 4'h0

`endif

// ---- hw/gds_pkg.sv ----
package gds_pkg;

  // ----------------------------------------
  // per-bridge sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    GDS_IDLE,
    GDS_OFF_WIN,
    GDS_DEAD,
    GDS_ON_WIN,
    GDS_HOLD
  } gds_state_type;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gds_pair_type;

  typedef struct packed {
    logic serial_variant;
    logic [3:0] gate_current_setting;
    logic [1:0] drive_window_control;
    logic [1:0] digital_dead_time;
    logic [3:0] vds_level;
    logic disable_gdf;
    logic disable_ocp;
    logic ocp_report_only;
  } gds_cfg_type;

  typedef struct packed {
    logic global;
    logic supply_undervoltage;
    logic [2:0] gate_drive_fault;
    logic [2:0] ocp_high;
    logic [2:0] ocp_low;
  } gds_status_type;

endpackage : gds_pkg

// ---- hw/gds_deglitch.sv ----
`timescale 1ns/1ns

module gds_deglitch #(
  parameter int WIDTH = 1,
  parameter int CYC = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  localparam int CW = $clog2(CYC + 1);

  // ----------------------------------------
  // one stability counter per bit
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt_r;
    logic out_r;
    wire differ = raw[i] ^ out_r;
    wire done = differ && (cnt_r == CW'(CYC - 1));
    // a change only passes after it has held for CYC cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_r <= '0;
        out_r <= 1'b0;
      end else begin
        cnt_r <= (differ && !done) ? cnt_r + 1'b1 : '0;
        out_r <= done ? raw[i] : out_r;
      end
    end
    assign clean[i] = out_r;
  end

endmodule : gds_deglitch

// ---- hw/gds_sequencer.sv ----
// Operation
// - next gate waits for opposite gate sensed off
// - serial variant adds programmable digital dead time
// - strong pulldown on opposite gate during window
// - one gate monitor per side per bridge
// - command change starts monitoring switching gate
// - gate not at threshold at window end faults
// - new command ends running window early
// - lowest four current codes auto select long window
// - long select writes ignored for other currents
// - pin variant never uses long window
// - inputs deglitched before reaching gate outputs
// - drain-source trip beyond deglitch declares overcurrent
// - high and low side trips sensed separately
// - trip level code selects threshold range
// - fault pin pulled low while any fault
// - supply not good within 100us flags undervoltage
// - undervoltage latches global and undervoltage flags
// - each fault sets its bit, global ors all
// - pin variant reports only through fault pin
// - protection features can be disabled
`timescale 1ns/1ns
`include "gds_map.svh"

module gds_sequencer
  import gds_pkg::*;
#(
  parameter int unsigned UV_WAIT_CYC = `GDS_UV_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pwm commands from the controller
  input wire gds_pair_type pwm_in,
  // gate-to-source monitors, high when gate above threshold
  input wire gds_pair_type vgs_ok,
  // drain-source comparators, high when above trip level
  input wire gds_pair_type vds_trip,
  // supply supervision
  input wire logic core_alive,
  input wire logic supply_ok,
  // configuration
  input wire gds_cfg_type cfg,
  input wire logic diag_select_n,
  input wire logic clear_faults,
  input wire logic long_window_we,
  input wire logic long_window_wdata,
  // gate drive
  output gds_pair_type gate_on_r,
  output gds_pair_type strong_pulldown_current_r,
  // comparator level select
  output logic [3:0] vds_level_r,
  // status
  output gds_status_type status_r,
  output logic long_window_select_r,
  output logic fault_line_low_r,
  // open-drain fault pin
  input wire logic fault_out_n_in,
  output logic fault_out_n_out_r,
  output logic fault_out_n_oe_r
);

  // ----------------------------------------
  // enables and variant selection
  // ----------------------------------------
  wire serial = cfg.serial_variant;
  wire gdf_stop_en = serial ? ~cfg.disable_gdf : 1'b1;
  wire ocp_en = serial ? ~cfg.disable_ocp : ~diag_select_n;
  logic shutdown_r;

  // ----------------------------------------
  // input deglitch
  // ----------------------------------------
  logic [5:0] pwm_clean_v;
  gds_pair_type pwm_clean;

  // noise on pwm pins shorter than GDS_PWM_DEG_CYC cycles never reaches the gates
  gds_deglitch #(
    .WIDTH(6),
    .CYC(`GDS_PWM_DEG_CYC)
  ) u_pwm_deg (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw({pwm_in.high, pwm_in.low}),
    .clean(pwm_clean_v)
  );
  assign pwm_clean = pwm_clean_v;

  // ----------------------------------------
  // long window select
  // ----------------------------------------
  logic low_prev_r;
  wire gate_current_setting_low = cfg.gate_current_setting <= `GDS_GATE_CURRENT_SETTING_LOW_MAX;
  wire gate_current_setting_enter = gate_current_setting_low & ~low_prev_r;
  wire lws_write = long_window_we & gate_current_setting_low;
  // auto select on entering the low range wins over a write in the same cycle
  wire lws_keep = gate_current_setting_low & long_window_select_r;
  wire lws_pick = gate_current_setting_enter | (lws_write ? long_window_wdata : lws_keep);
  wire lws_nxt = serial & lws_pick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_prev_r <= 1'b0;
      long_window_select_r <= 1'b0;
    end else begin
      low_prev_r <= gate_current_setting_low;
      long_window_select_r <= lws_nxt;
    end
  end

  // ----------------------------------------
  // window and dead time counts
  // ----------------------------------------
  wire [1:0] dwc = cfg.drive_window_control;
  wire [1:0] ddt = cfg.digital_dead_time;
  wire [`GDS_CNT_W-1:0] win_base =
    (dwc == 2'h0) ? `GDS_CNT_W'(`GDS_WIN0_CYC) :
    (dwc == 2'h1) ? `GDS_CNT_W'(`GDS_WIN1_CYC) :
    (dwc == 2'h2) ? `GDS_CNT_W'(`GDS_WIN2_CYC) :
    `GDS_CNT_W'(`GDS_WIN3_CYC);
  wire [`GDS_CNT_W-1:0] win_cyc =
    long_window_select_r ? `GDS_CNT_W'(`GDS_WIN_LONG_CYC) : win_base;
  // counter runs down to zero, so load one less than the window
  wire [`GDS_CNT_W-1:0] win_load = win_cyc - 1'b1;
  wire [`GDS_CNT_W-1:0] dead_sel =
    (ddt == 2'h0) ? '0 :
    (ddt == 2'h1) ? `GDS_CNT_W'(`GDS_DEAD1_CYC) :
    (ddt == 2'h2) ? `GDS_CNT_W'(`GDS_DEAD2_CYC) :
    `GDS_CNT_W'(`GDS_DEAD3_CYC);
  wire [`GDS_CNT_W-1:0] dead_load = serial ? dead_sel : '0;

  // ----------------------------------------
  // per-bridge sequencer
  // ----------------------------------------
  logic [2:0] gh_nxt_v;
  logic [2:0] gl_nxt_v;
  logic [2:0] pdh_nxt_v;
  logic [2:0] pdl_nxt_v;
  logic [2:0] gdf_ev_v;

  for (genvar b = 0; b < 3; b++) begin : g_br
    gds_state_type st_r;
    gds_state_type st_nxt;
    logic [`GDS_CNT_W-1:0] cnt_r;
    logic [`GDS_CNT_W-1:0] cnt_nxt;
    logic [1:0] cmd_r;
    logic [1:0] cmd_nxt;
    logic sw_hi_r;
    logic sw_hi_nxt;
    logic gh_nxt;
    logic gl_nxt;
    logic gdf_ev;
    // both inputs high is taken as both off
    wire want_hi = pwm_clean.high[b] & ~pwm_clean.low[b];
    wire want_lo = pwm_clean.low[b] & ~pwm_clean.high[b];
    wire [1:0] want = {want_hi, want_lo};
    wire new_cmd = want != cmd_r;
    wire gh = gate_on_r.high[b];
    wire gl = gate_on_r.low[b];
    wire vgs_sw = sw_hi_r ? vgs_ok.high[b] : vgs_ok.low[b];
    wire vgs_opp = sw_hi_r ? vgs_ok.low[b] : vgs_ok.high[b];
    wire cnt_zero = cnt_r == '0;
    wire drop_on = (gh & ~want_hi) | (gl & ~want_lo);
    wire in_win = (st_nxt == GDS_ON_WIN) || (st_nxt == GDS_OFF_WIN);

    always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      cmd_nxt = cmd_r;
      sw_hi_nxt = sw_hi_r;
      gh_nxt = gh;
      gl_nxt = gl;
      gdf_ev = 1'b0;
      if (shutdown_r) begin
        st_nxt = GDS_IDLE;
        cmd_nxt = 2'b00;
        gh_nxt = 1'b0;
        gl_nxt = 1'b0;
      end else if (new_cmd) begin
        // a fresh command cuts any running window short
        cmd_nxt = want;
        if (drop_on) begin
          sw_hi_nxt = gh;
          gh_nxt = gh & want_hi;
          gl_nxt = gl & want_lo;
          cnt_nxt = win_load;
          st_nxt = GDS_OFF_WIN;
        end else if (want_hi | want_lo) begin
          sw_hi_nxt = want_hi;
          cnt_nxt = dead_load;
          st_nxt = GDS_DEAD;
        end else begin
          st_nxt = GDS_IDLE;
        end
      end else begin
        case (st_r)
          GDS_OFF_WIN: begin
            if (!vgs_sw) begin
              // gate seen off: hand over without waiting for the window
              if (|cmd_r) begin
                sw_hi_nxt = cmd_r[1];
                cnt_nxt = dead_load;
                st_nxt = GDS_DEAD;
              end else begin
                st_nxt = GDS_IDLE;
              end
            end else if (cnt_zero) begin
              gdf_ev = 1'b1;
              st_nxt = GDS_IDLE;
            end else begin
              cnt_nxt = cnt_r - 1'b1;
            end
          end
          GDS_DEAD: begin
            // a stuck opposite gate holds the bridge off indefinitely
            if (cnt_zero && !vgs_opp) begin
              gh_nxt = sw_hi_r;
              gl_nxt = ~sw_hi_r;
              cnt_nxt = win_load;
              st_nxt = GDS_ON_WIN;
            end else if (!cnt_zero) begin
              cnt_nxt = cnt_r - 1'b1;
            end
          end
          GDS_ON_WIN: begin
            if (cnt_zero) begin
              gdf_ev = ~vgs_sw;
              st_nxt = GDS_HOLD;
            end else begin
              cnt_nxt = cnt_r - 1'b1;
            end
          end
          default: begin
            st_nxt = st_r;
          end
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        st_r <= GDS_IDLE;
        cnt_r <= '0;
        cmd_r <= 2'b00;
        sw_hi_r <= 1'b0;
      end else begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
        cmd_r <= cmd_nxt;
        sw_hi_r <= sw_hi_nxt;
      end
    end

    assign gh_nxt_v[b] = gh_nxt;
    assign gl_nxt_v[b] = gl_nxt;
    assign pdh_nxt_v[b] = in_win & ~sw_hi_nxt;
    assign pdl_nxt_v[b] = in_win & sw_hi_nxt;
    assign gdf_ev_v[b] = gdf_ev;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_on_r <= '0;
      strong_pulldown_current_r <= '0;
    end else begin
      gate_on_r <= {gh_nxt_v, gl_nxt_v};
      strong_pulldown_current_r <= {pdh_nxt_v, pdl_nxt_v};
    end
  end

  // ----------------------------------------
  // drain-source overcurrent
  // ----------------------------------------
  logic [5:0] vds_clean_v;
  // only an enabled mosfet is watched, its own comparator per side
  wire [2:0] vds_hi_raw = vds_trip.high & gate_on_r.high & {3{ocp_en}};
  wire [2:0] vds_lo_raw = vds_trip.low & gate_on_r.low & {3{ocp_en}};

  gds_deglitch #(
    .WIDTH(6),
    .CYC(`GDS_OCP_DEG_CYC)
  ) u_vds_deg (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw({vds_hi_raw, vds_lo_raw}),
    .clean(vds_clean_v)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vds_level_r <= `GDS_VDS_LVL_RST;
    end else begin
      vds_level_r <= cfg.vds_level;
    end
  end

  // ----------------------------------------
  // power-up undervoltage window
  // ----------------------------------------
  logic alive_prev_r;
  logic uv_arm_r;
  logic [`GDS_UV_W-1:0] uv_cnt_r;
  wire alive_rise = core_alive & ~alive_prev_r;
  wire uv_last = uv_cnt_r == `GDS_UV_W'(UV_WAIT_CYC - 1);
  wire uv_ev = uv_arm_r & ~supply_ok & uv_last;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alive_prev_r <= 1'b0;
      uv_arm_r <= 1'b0;
      uv_cnt_r <= '0;
    end else begin
      alive_prev_r <= core_alive;
      uv_arm_r <= alive_rise | (uv_arm_r & ~supply_ok & ~uv_last);
      uv_cnt_r <= (alive_rise | ~uv_arm_r) ? '0 : uv_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // fault latches and reporting
  // ----------------------------------------
  logic [2:0] gdf_r;
  logic [2:0] ocp_hi_r;
  logic [2:0] ocp_lo_r;
  logic uv_r;
  // a clear takes effect at once on gate faults, on the others only once the condition has gone; a new event wins
  wire [2:0] gdf_nxt = gdf_ev_v | (gdf_r & ~{3{clear_faults}});
  wire [2:0] ocp_hi_nxt = vds_clean_v[5:3] | (ocp_hi_r & ~{3{clear_faults}});
  wire [2:0] ocp_lo_nxt = vds_clean_v[2:0] | (ocp_lo_r & ~{3{clear_faults}});
  wire uv_nxt = uv_ev | (uv_r & ~(clear_faults & supply_ok));
  wire ocp_any = |{ocp_hi_nxt, ocp_lo_nxt};
  wire any_nxt = uv_nxt | (|gdf_nxt) | ocp_any;
  // report-only overcurrent and disabled gate faults keep the bridges running
  wire stop_nxt = uv_nxt | (gdf_stop_en & (|gdf_nxt)) | (ocp_any & ~cfg.ocp_report_only);
  wire gds_status_type stat_nxt = {any_nxt, uv_nxt, gdf_nxt, ocp_hi_nxt, ocp_lo_nxt};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gdf_r <= 3'h0;
      ocp_hi_r <= 3'h0;
      ocp_lo_r <= 3'h0;
      uv_r <= 1'b0;
      shutdown_r <= 1'b0;
    end else begin
      gdf_r <= gdf_nxt;
      ocp_hi_r <= ocp_hi_nxt;
      ocp_lo_r <= ocp_lo_nxt;
      uv_r <= uv_nxt;
      shutdown_r <= stop_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
      fault_out_n_out_r <= 1'b0;
      fault_out_n_oe_r <= 1'b0;
      fault_line_low_r <= 1'b0;
    end else begin
      status_r <= serial ? stat_nxt : '0;
      fault_out_n_out_r <= 1'b0;
      fault_out_n_oe_r <= any_nxt;
      fault_line_low_r <= ~fault_out_n_in;
    end
  end

endmodule : gds_sequencer

// ---- bench/gds_gate_model.sv ----
`timescale 1ns/1ns
module gds_gate_model
  import gds_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // gates and their monitors
  input wire gds_pair_type gate_on,
  input wire gds_pair_type stuck,
  input wire logic slow,
  output gds_pair_type vgs_ok,
  // open-drain fault line, pulled up
  input wire logic fo_out,
  input wire logic fo_oe,
  output logic fo_level
);
  // ----------------------------------------
  // gate charge, always shorter than a window
  // ----------------------------------------
  logic [5:0] lvl_r = 6'h00;
  int cnt_r [6] = '{default: 0};
  always @(posedge sys_clk) begin
    for (int i = 0; i < 6; i++) begin
      // a stuck gate never charges, so its monitor stays low
      if (gate_on[i] == lvl_r[i] || (stuck[i] && gate_on[i])) begin
        cnt_r[i] <= 0;
      end else if (cnt_r[i] >= (slow ? 20 : 3)) begin
        lvl_r[i] <= gate_on[i];
        cnt_r[i] <= 0;
      end else begin
        cnt_r[i] <= cnt_r[i] + 1;
      end
    end
  end
  assign vgs_ok = gds_pair_type'(lvl_r);
  assign fo_level = fo_oe ? fo_out : 1'b1;
endmodule : gds_gate_model

// ---- bench/gds_sequencer_checker.sv ----
`timescale 1ns/1ns
module gds_sequencer_checker
  import gds_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched inputs
  input wire gds_pair_type vgs_ok,
  input wire gds_cfg_type cfg,
  // watched outputs
  input wire gds_pair_type gate_on_r,
  input wire gds_pair_type strong_pulldown_current_r,
  input wire gds_status_type status_r,
  input wire logic long_window_select_r,
  input wire logic fault_out_n_oe_r
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence high0_rise;
    $rose(gate_on_r.high[0]);
  endsequence
  sequence pin_steady;
    !cfg.serial_variant [*2];
  endsequence
  chk_no_shoot_through: assert property ((gate_on_r.high & gate_on_r.low) == 3'h0)
    else $error("both gates of a bridge on");
  chk_dead_gate_wait: assert property (((gate_on_r.high & ~$past(gate_on_r.high)
    & $past(vgs_ok.low)) | (gate_on_r.low & ~$past(gate_on_r.low) & $past(vgs_ok.high)))
    == 3'h0) else $error("gate on while opposite still sensed on");
  chk_pulldown_hold: assert property (high0_rise |-> strong_pulldown_current_r.low[0] [*4])
    else $error("opposite pulldown missing at switch");
  chk_global_or: assert property (status_r.global == |status_r[9:0])
    else $error("global flag differs from or of flags");
  chk_pin_no_status: assert property (pin_steady |-> status_r == '0)
    else $error("status bits on pin variant");
  chk_fault_pin: assert property (cfg.serial_variant |-> fault_out_n_oe_r == status_r.global)
    else $error("fault pin disagrees with flags");
  chk_long_pin_off: assert property (!cfg.serial_variant |=> !long_window_select_r)
    else $error("long window on pin variant");
  chk_long_ignore: assert property ((cfg.serial_variant && cfg.gate_current_setting > 4'h3)
    [*2] |=> !long_window_select_r) else $error("long window kept at high current");
  chk_gdf_shutdown: assert property ($rose(|status_r.gate_drive_fault) && !cfg.disable_gdf
    |-> ##[1:2] gate_on_r == '0) else $error("gates on after gate fault");
endmodule : gds_sequencer_checker

bind gds_sequencer gds_sequencer_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .vgs_ok(vgs_ok), .cfg(cfg), .gate_on_r(gate_on_r), .status_r(status_r),
  .strong_pulldown_current_r(strong_pulldown_current_r), .fault_out_n_oe_r(fault_out_n_oe_r),
  .long_window_select_r(long_window_select_r));

// ---- bench/gds_sequencer_bench.sv ----
`timescale 1ns/1ns
`include "gds_map.svh"
module gds_sequencer_bench;
  import gds_pkg::*;
  // ----------------------------------------
  // stimulus, notes and checking
  // ----------------------------------------
  localparam int UVW = 50;
  typedef struct {int kind; logic [11:0] val;} gds_note_type;
  logic sys_clk = 0, rst_n = 0, core_alive = 0, supply_ok = 1, clear_faults = 0, slow = 0;
  logic long_window_we = 0, long_window_wdata = 0, lws_r, fll_r, fo_in, fo_out, fo_oe;
  logic diag_n = 0;
  logic [3:0] lvl_r;
  logic [11:0] meas;
  gds_pair_type pwm_in = '0, vds_trip = '0, stuck = '0, vgs_ok, gate_on_r, pull_r;
  gds_cfg_type cfg = '0;
  gds_status_type status_r;
  gds_note_type notes[$];
  int failures = 0, checks_done = 0, seed = 37, n;
  int dead_c[4] = '{0, `GDS_DEAD1_CYC, `GDS_DEAD2_CYC, `GDS_DEAD3_CYC};
  int win_c[4] = '{`GDS_WIN0_CYC, `GDS_WIN1_CYC, `GDS_WIN2_CYC, `GDS_WIN3_CYC};
  event take_ev;
  always #4 sys_clk = ~sys_clk;
  gds_sequencer #(.UV_WAIT_CYC(UVW)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .pwm_in(pwm_in),
    .vgs_ok(vgs_ok), .vds_trip(vds_trip), .core_alive(core_alive), .supply_ok(supply_ok),
    .cfg(cfg), .diag_select_n(diag_n), .clear_faults(clear_faults), .status_r(status_r),
    .long_window_we(long_window_we), .long_window_wdata(long_window_wdata),
    .gate_on_r(gate_on_r), .strong_pulldown_current_r(pull_r), .vds_level_r(lvl_r),
    .long_window_select_r(lws_r), .fault_line_low_r(fll_r), .fault_out_n_in(fo_in),
    .fault_out_n_out_r(fo_out), .fault_out_n_oe_r(fo_oe));
  gds_gate_model u_model (.sys_clk(sys_clk), .gate_on(gate_on_r), .stuck(stuck),
    .slow(slow), .vgs_ok(vgs_ok), .fo_out(fo_out), .fo_oe(fo_oe), .fo_level(fo_in));

  task automatic tick(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic note(int k, logic [11:0] v);
    notes.push_back('{k, v});
    -> take_ev;
  endtask : note
  task automatic cmp(logic [11:0] e, logic [11:0] a);
    checks_done++;
    if (a !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic restart(logic ser);
    rst_n = 0;
    cfg = '0;
    cfg.serial_variant = ser;
    cfg.gate_current_setting = 4'h7;
    tick(12);
    rst_n = 1;
    tick(2);
  endtask : restart
  task automatic clear();
    clear_faults = 1;
    tick(1);
    clear_faults = 0;
    tick(3);
  endtask : clear
  task automatic wait_gates(gds_pair_type e);
    for (n = 0; gate_on_r !== e && n < 3000; n++) tick(1);
    note(0, {6'h0, e});
  endtask : wait_gates
  task automatic lw_write(logic v);
    long_window_wdata = v;
    long_window_we = 1;
    tick(1);
    long_window_we = 0;
    tick(2);
  endtask : lw_write
  // low to high on bridge 0: measure dead gap and opposite pulldown length
  task automatic swing(int dc, int wc);
    int k;
    pwm_in = 6'h01;
    wait_gates(6'h01);
    tick(wc + 20);
    pwm_in = 6'h08;
    for (k = 0; gate_on_r.low[0] !== 1'b0 && k < 99; k++) tick(1);
    for (k = 0; gate_on_r.high[0] !== 1'b1 && k < 999; k++) tick(1);
    meas = 12'(k >= dc + 3);
    note(4, 12'h001);
    for (k = 0; pull_r.low[0] === 1'b1 && k < 3000; k++) tick(1);
    meas = 12'(k >= wc - 2 && k <= wc + 2);
    note(4, 12'h001);
  endtask : swing

  // results are compared as they come due, oldest note first
  initial begin
    gds_note_type nt;
    logic [11:0] act;
    forever begin
      @(take_ev);
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        case (nt.kind)
          0: act = {6'h0, gate_on_r};
          1: act = {1'b0, status_r};
          2: act = {11'h0, fll_r};
          3: act = {11'h0, lws_r};
          5: act = {8'h0, lvl_r};
          default: act = meas;
        endcase
        cmp(nt.val, act);
      end
    end
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  initial begin
    restart(1);
    for (int c = 0; c < 4; c++) begin
      cfg.digital_dead_time = 2'(c);
      cfg.drive_window_control = 2'(c);
      cfg.vds_level = 4'($random(seed));
      swing(dead_c[c], win_c[c]);
      note(5, {8'h0, cfg.vds_level});
    end
    cfg.digital_dead_time = 2'h0;
    cfg.drive_window_control = 2'h0;
    cfg.gate_current_setting = 4'h2;
    tick(3);
    note(3, 12'h001);
    swing(0, `GDS_WIN_LONG_CYC);
    lw_write(1'b0);
    note(3, 12'h000);
    swing(0, win_c[0]);
    cfg.gate_current_setting = 4'h9;
    lw_write(1'b1);
    note(3, 12'h000);
    $display("end of dead time and window test");
    pwm_in = 6'h01;
    tick(2);
    pwm_in = 6'h08;
    tick(30);
    note(0, 12'h008);
    for (int i = 0; i < 16; i++) begin
      n = $random(seed);
      slow = n[8];
      pwm_in = n[5:0];
      wait_gates(n[5:0] & ~{n[5:3] & n[2:0], n[5:3] & n[2:0]});
    end
    pwm_in = '0;
    wait_gates('0);
    note(1, 12'h000);
    slow = 0;
    $display("end of random command test");
    for (int d = 0; d < 2; d++) begin
      cfg.disable_gdf = d[0];
      stuck = 6'h10;
      pwm_in = 6'h10;
      tick(200);
      note(1, 12'h480);
      note(2, 12'h001);
      note(0, d ? 12'h010 : 12'h000);
      stuck = '0;
      pwm_in = '0;
      tick(100);
      clear();
      note(1, 12'h000);
    end
    cfg.disable_gdf = 0;
    $display("end of gate fault test");
    for (int s = 0; s < 2; s++) begin
      pwm_in = s ? 6'h20 : 6'h04;
      // second pass runs report-only: the gate must stay on
      cfg.ocp_report_only = s[0];
      wait_gates(pwm_in);
      vds_trip = pwm_in;
      tick(300);
      vds_trip = '0;
      tick(10);
      note(1, 12'h000);
      vds_trip = pwm_in;
      tick(600);
      note(1, s ? 12'h420 : 12'h404);
      note(0, s ? 12'h020 : 12'h000);
      vds_trip = '0;
      pwm_in = '0;
      // clear only bites once the filtered trip has fallen, 500 cycles on
      tick(520);
      clear();
      note(1, 12'h000);
    end
    $display("end of overcurrent test");
    supply_ok = 0;
    core_alive = 1;
    tick(UVW + 10);
    note(1, 12'h600);
    supply_ok = 1;
    clear();
    note(1, 12'h000);
    restart(0);
    cfg.gate_current_setting = 4'h1;
    core_alive = 0;
    supply_ok = 0;
    tick(2);
    core_alive = 1;
    tick(UVW + 10);
    note(2, 12'h001);
    note(1, 12'h000);
    note(3, 12'h000);
    supply_ok = 1;
    clear();
    diag_n = 1;
    pwm_in = 6'h01;
    wait_gates(6'h01);
    vds_trip = 6'h01;
    tick(600);
    note(2, 12'h000);
    note(0, 12'h001);
    diag_n = 0;
    tick(600);
    note(2, 12'h001);
    $display("end of undervoltage test");
    tick(2);
    give_verdict();
  end
endmodule : gds_sequencer_bench
